//--- rtl/gpl_pkg.sv
/*
 * gpl_pkg: constants for the low pin bank configuration block.
 * Assumes a 32-bit classic Wishbone register bus with byte addresses.
 */
package gpl_pkg;
    localparam int          GPL_PINS          = 8;
    localparam int          GPL_ADDR_W        = 12;
    // register byte offsets
    localparam logic [11:0] GPL_CFG_OFF       = 12'h028;
    localparam logic [11:0] GPL_WAKE_OFF      = 12'h100;
    localparam logic [11:0] GPL_ISTAT_OFF     = 12'h104;
    localparam logic [11:0] GPL_IMASK_OFF     = 12'h108;
    localparam logic [11:0] GPL_CTRL_OFF      = 12'h10C;
    // field positions inside the configuration word
    localparam int          GPL_VAL_LSB       = 0;
    localparam int          GPL_DIR_LSB       = 8;
    localparam int          GPL_DRV_LSB       = 16;
    localparam int          GPL_FSEL_LSB      = 24;
    // status / mask word: interrupt events low byte, wake events next byte
    localparam int          GPL_IRQ_LSB       = 0;
    localparam int          GPL_WAKEV_LSB     = 8;
    // control word bit
    localparam int          GPL_MIRROR_BIT    = 0;
    // reset values
    localparam logic [7:0]  GPL_FSEL_RST      = 8'hFF;
    localparam logic [7:0]  GPL_DRV_RST       = 8'h00;
    localparam logic [7:0]  GPL_DIR_RST       = 8'h00;
    localparam logic [7:0]  GPL_VAL_RST       = 8'h00;
    localparam logic [7:0]  GPL_WAKE_RST      = 8'h00;
    localparam logic [15:0] GPL_STAT_RST      = 16'h0000;
    localparam logic [15:0] GPL_MASK_RST      = 16'h0000;
endpackage

//--- rtl/gpl_bank.sv
/*
 * gpl_bank: low bank of eight general purpose pins with a Wishbone slave,
 * pin edge events, wake qualification and one level interrupt.
 * Assumes pins are asynchronous to mclk_i; the pad resolves o/oe into a wire,
 * and the MII side provides the mirror signals and the mode select strap.
 */
// The Wishbone interface to the registers is this design's own decision.
`timescale 1ns/1ps

module gpl_bank
    import gpl_pkg::*;
#(
    parameter int N = GPL_PINS
) (
    input  wire logic            mclk_i,
    input  wire logic            rst_n_i,
    // classic wishbone slave
    input  wire logic            wb_cyc_i,
    input  wire logic            wb_stb_i,
    input  wire logic            wb_we_i,
    input  wire logic [11:0]     wb_adr_i,
    input  wire logic [3:0]      wb_sel_i,
    input  wire logic [31:0]     wb_dat_i,
    output logic      [31:0]     wb_dat_o,
    output logic                 wb_ack_o,
    output logic                 wb_err_o,
    // pins
    input  wire logic [N-1:0]    pin_i,
    output logic      [N-1:0]    pin_o,
    output logic      [N-1:0]    pin_oe_o,
    // surroundings
    input  wire logic            ext_mii_mode_i,
    input  wire logic [N-1:0]    mii_mirror_i,
    output logic                 irq_o,
    output logic                 wake_o
);

    typedef struct packed {
        logic [N-1:0]  fsel;
        logic [N-1:0]  drv;
        logic [N-1:0]  dir;
        logic [N-1:0]  val;
        logic [N-1:0]  wake_en;
        logic [15:0]   stat;
        logic [15:0]   mask;
        logic          mirror;
        logic [N-1:0]  s1;
        logic [N-1:0]  s2;
        logic [N-1:0]  s3;
        logic [N-1:0]  lvl;
        logic          mii1;
        logic          mii2;
        logic          mii3;
        logic          mii;
        logic [31:0]   rdata;
        logic          ack;
        logic          err;
        logic [N-1:0]  po;
        logic [N-1:0]  poe;
        logic          irq;
        logic          wake;
    } gpl_state_t;

    gpl_state_t st;
    gpl_state_t next_st;

    // byte-lane merge of a write into an 8-bit field at a byte boundary
    function automatic logic [7:0] lane(input logic [7:0] old, input logic [31:0] d,
                                        input logic [3:0] sel, input int lsb);
        lane = sel[lsb/8] ? d[lsb +: 8] : old;
    endfunction

    logic          hit;
    logic          wr;
    logic [N-1:0]  rise;
    logic [N-1:0]  ev_irq;
    logic [N-1:0]  ev_wake;
    logic [15:0]   ev_all;
    logic [15:0]   w1c;
    logic [N-1:0]  gp_out;
    logic [N-1:0]  mir_out;
    logic [N-1:0]  drive_val;

    always_comb begin
        next_st = st;
        // pins pass three flops; a level change counts once stages 2 and 3 agree
        next_st.s1 = pin_i;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        for (int i = 0; i < N; i++) begin
            if (st.s2[i] == st.s3[i]) begin
                next_st.lvl[i] = st.s3[i];
            end
        end
        next_st.mii1 = ext_mii_mode_i;
        next_st.mii2 = st.mii1;
        next_st.mii3 = st.mii2;
        if (st.mii2 == st.mii3) begin
            next_st.mii = st.mii3;
        end

        // events: any filtered level change on a general purpose input while external mii mode is off
        rise    = next_st.lvl ^ st.lvl;
        ev_irq  = rise & ~st.dir & ~st.fsel & {N{~st.mii}};
        ev_wake = ev_irq & st.wake_en;
        ev_all  = 16'(ev_irq) | (16'(ev_wake) << GPL_WAKEV_LSB);

        hit = wb_cyc_i && wb_stb_i && !st.ack && !st.err;
        wr  = hit && wb_we_i;
        w1c = '0;
        next_st.ack   = 1'b0;
        next_st.err   = 1'b0;
        next_st.rdata = '0;
        if (hit) begin
            unique case (wb_adr_i)
                GPL_CFG_OFF: begin
                    next_st.ack = 1'b1;
                    if (wr) begin
                        next_st.fsel = lane(st.fsel, wb_dat_i, wb_sel_i, GPL_FSEL_LSB);
                        next_st.drv  = lane(st.drv, wb_dat_i, wb_sel_i, GPL_DRV_LSB);
                        next_st.dir  = lane(st.dir, wb_dat_i, wb_sel_i, GPL_DIR_LSB);
                        next_st.val  = lane(st.val, wb_dat_i, wb_sel_i, GPL_VAL_LSB);
                    end
                    // data field reads the pins, never the written value
                    next_st.rdata = {st.fsel, st.drv, st.dir, st.lvl};
                end
                GPL_WAKE_OFF: begin
                    next_st.ack = 1'b1;
                    if (wr) begin
                        next_st.wake_en = lane(st.wake_en, wb_dat_i, wb_sel_i, 0);
                    end
                    next_st.rdata = {24'h000000, st.wake_en};
                end
                GPL_ISTAT_OFF: begin
                    next_st.ack = 1'b1;
                    if (wr) begin
                        w1c = wb_dat_i[15:0] & {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
                    end
                    next_st.rdata = {16'h0000, st.stat};
                end
                GPL_IMASK_OFF: begin
                    next_st.ack = 1'b1;
                    if (wr) begin
                        next_st.mask[7:0]  = lane(st.mask[7:0], wb_dat_i, wb_sel_i, 0);
                        next_st.mask[15:8] = lane(st.mask[15:8], wb_dat_i, wb_sel_i, 8);
                    end
                    next_st.rdata = {16'h0000, st.mask};
                end
                GPL_CTRL_OFF: begin
                    next_st.ack = 1'b1;
                    if (wr && wb_sel_i[0]) begin
                        next_st.mirror = wb_dat_i[GPL_MIRROR_BIT];
                    end
                    next_st.rdata = {30'h00000000, st.mii, st.mirror};
                end
                default: begin
                    next_st.err = 1'b1;
                end
            endcase
        end
        // a new event wins over a clear in the same cycle
        next_st.stat = (st.stat & ~w1c) | ev_all;
        next_st.irq  = |(next_st.stat[7:0] & next_st.mask[7:0]);
        next_st.wake = |(next_st.stat[15:8] & next_st.mask[15:8]);

        // pad drive
        gp_out    = st.dir & ~st.fsel;
        mir_out   = st.fsel & {N{st.mirror}};
        drive_val = (st.val & gp_out) | (mii_mirror_i & mir_out);
        for (int i = 0; i < N; i++) begin
            if (st.mii) begin
                next_st.poe[i] = 1'b0;
                next_st.po[i]  = 1'b0;
            end else if (gp_out[i] && !st.drv[i]) begin
                next_st.po[i]  = 1'b0;
                next_st.poe[i] = !st.val[i];
            end else begin
                next_st.po[i]  = drive_val[i];
                next_st.poe[i] = gp_out[i] | mir_out[i];
            end
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st         <= '0;
            st.fsel    <= GPL_FSEL_RST;
            st.drv     <= GPL_DRV_RST;
            st.dir     <= GPL_DIR_RST;
            st.val     <= GPL_VAL_RST;
            st.wake_en <= GPL_WAKE_RST;
            st.stat    <= GPL_STAT_RST;
            st.mask    <= GPL_MASK_RST;
        end else begin
            st <= next_st;
        end
    end

    assign wb_dat_o = st.rdata;
    assign wb_ack_o = st.ack;
    assign wb_err_o = st.err;
    assign pin_o    = st.po;
    assign pin_oe_o = st.poe;
    assign irq_o    = st.irq;
    assign wake_o   = st.wake;

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_mii_on;
        st.mii [*2];
    endsequence

    a_mii_no_drive: assert property (s_mii_on |-> pin_oe_o == '0)
        else $error("pin driven in external mii mode");
    a_event_input: assert property (|(ev_irq & st.dir) == 1'b0)
        else $error("event taken from an output pin");
    a_wake_needs_en: assert property (
        ((ev_wake & ~st.wake_en) == '0))
        else $error("wake event without enable");
    a_fsel_reset: assert property (
        $rose(rst_n_i) |-> st.fsel == GPL_FSEL_RST)
        else $error("function select reset wrong");
    a_mirror_copy: assert property (
        (!st.mii && st.mirror && st.fsel[0]) |=> (pin_o[0] == $past(mii_mirror_i[0])))
        else $error("mirror pin does not follow mii signal");
    a_pp_drive: assert property (
        (!st.mii && st.dir[0] && !st.fsel[0] && st.drv[0])
        |=> (pin_oe_o[0] && pin_o[0] == $past(st.val[0])))
        else $error("push-pull output does not show data");
    a_od_drive: assert property (
        (!st.mii && st.dir[0] && !st.fsel[0] && !st.drv[0])
        |=> (pin_o[0] == 1'b0 && pin_oe_o[0] == !$past(st.val[0])))
        else $error("open-drain output wrong");
    a_data_reads_pin: assert property (
        (hit && !wb_we_i && wb_adr_i == GPL_CFG_OFF)
        |=> wb_dat_o[7:0] == $past(st.lvl))
        else $error("data read not the pin level");
    a_dir_reset: assert property (
        $rose(rst_n_i) |-> (st.dir == GPL_DIR_RST && st.drv == GPL_DRV_RST))
        else $error("direction or drive reset wrong");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_err_pulse: assert property (wb_err_o |=> !wb_err_o)
        else $error("err longer than one cycle");

    // bus handshake steps shared by the access checks below
    sequence s_take;
        hit;
    endsequence

    sequence s_answer;
        wb_ack_o ^ wb_err_o;
    endsequence

    sequence s_cfg_write;
        hit && wb_we_i && wb_adr_i == GPL_CFG_OFF && wb_sel_i == 4'hF;
    endsequence

    sequence s_stat_clear;
        (w1c != '0) && (ev_all == '0);
    endsequence

    a_take_answer: assert property (s_take |=> s_answer)
        else $error("taken request not answered once");
    a_answer_no_take: assert property (s_answer |-> !hit)
        else $error("new request taken while answering");
    a_rdata_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h00000000)
        else $error("read data not zero outside ack");
    a_unmapped_err: assert property (
        (hit && wb_adr_i != GPL_CFG_OFF && wb_adr_i != GPL_WAKE_OFF
         && wb_adr_i != GPL_ISTAT_OFF && wb_adr_i != GPL_IMASK_OFF
         && wb_adr_i != GPL_CTRL_OFF) |=> (wb_err_o && !wb_ack_o))
        else $error("unmapped address not refused");
    a_cfg_fields: assert property (
        s_cfg_write |=> (st.fsel == $past(wb_dat_i[31:24])
                         && st.drv == $past(wb_dat_i[23:16])
                         && st.dir == $past(wb_dat_i[15:8])))
        else $error("configuration write not stored");
    a_wake_en_write: assert property (
        (hit && wb_we_i && wb_adr_i == GPL_WAKE_OFF && wb_sel_i[0])
        |=> st.wake_en == $past(wb_dat_i[7:0]))
        else $error("wake enable write not stored");
    a_mask_write: assert property (
        (hit && wb_we_i && wb_adr_i == GPL_IMASK_OFF && wb_sel_i[1:0] == 2'b11)
        |=> st.mask == $past(wb_dat_i[15:0]))
        else $error("mask write not stored");
    a_ctrl_read: assert property (
        (hit && !wb_we_i && wb_adr_i == GPL_CTRL_OFF)
        |=> wb_dat_o[1:0] == {$past(st.mii), $past(st.mirror)})
        else $error("control read wrong");
    a_val_reset: assert property (
        $rose(rst_n_i) |-> (st.val == GPL_VAL_RST && st.stat == GPL_STAT_RST
                            && st.mask == GPL_MASK_RST && st.wake_en == GPL_WAKE_RST))
        else $error("data, status or mask reset wrong");

    // status and the two level outputs
    a_irq_level: assert property (irq_o == |(st.stat[7:0] & st.mask[7:0]))
        else $error("interrupt not the masked status");
    a_wake_level: assert property (
        wake_o == |(st.stat[15:8] & st.mask[15:8]))
        else $error("wake not the masked wake status");
    a_event_sticky: assert property (
        (ev_all != '0) |=> ((st.stat & $past(ev_all)) == $past(ev_all)))
        else $error("event lost in status");
    a_stat_clear: assert property (s_stat_clear |=> ((st.stat & $past(w1c)) == '0))
        else $error("status not cleared by writing one");

    // a level may only move once the last two stages agree, else glitches make events
    a_level_filter: assert property (
        (st.lvl[0] != $past(st.lvl[0]))
        |-> (st.lvl[0] == $past(st.s3[0]) && $past(st.s2[0]) == $past(st.s3[0])))
        else $error("pin level taken before stages agree");
    a_mii_filter: assert property (
        (st.mii != $past(st.mii))
        |-> (st.mii == $past(st.mii3) && $past(st.mii2) == $past(st.mii3)))
        else $error("mii mode taken before stages agree");
    a_mii_no_event: assert property (st.mii |-> ev_all == '0)
        else $error("event raised in external mii mode");
    a_mii_low_out: assert property (s_mii_on |-> pin_o == '0)
        else $error("pin value not parked in external mii mode");

    // pad enables per mode
    a_gp_off_released: assert property (
        (!st.mirror && st.fsel[0]) |=> !pin_oe_o[0])
        else $error("disabled pin driven without mirror");
    a_mirror_drives: assert property (
        (!st.mii && st.mirror && st.fsel[0]) |=> pin_oe_o[0])
        else $error("mirror pin not driven");
    a_input_released: assert property (
        (!st.fsel[0] && !st.dir[0]) |=> !pin_oe_o[0])
        else $error("input pin driven");

endmodule

//--- sim/gpl_board.sv
/*
 * gpl_board: pads and board wiring around the low pin bank.
 * Assumes a pull-up on every pin and a bench-driven external source per pin.
 */
`timescale 1ns/1ps
module gpl_board (
    input  wire logic [7:0] drv_i,
    input  wire logic [7:0] drv_oe_i,
    input  wire logic [7:0] ext_v_i,
    input  wire logic [7:0] ext_en_i,
    output logic      [7:0] lvl_o
);
    always_comb begin
        for (int k = 0; k < 8; k++) begin
            // a released pad with no external source enabled is pulled high, so open-drain ones read back high
            lvl_o[k] = drv_oe_i[k] ? drv_i[k] : (ext_en_i[k] ? ext_v_i[k] : 1'b1);
        end
    end
endmodule

//--- sim/tb_top.sv
/*
 * tb_top: register-level bench for the low pin bank.
 * Assumes the board model resolves the pads; all waits are bounded.
 */
`timescale 1ns/1ps
module tb_top;
    import gpl_pkg::*;
    logic        mclk_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic        mii = 1'b0;
    logic [11:0] adr = 12'h000;
    logic [3:0]  sel = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic [31:0] dat_o;
    logic        ack;
    logic        err;
    logic        e;
    logic        irq;
    logic        wake;
    logic [7:0]  pin_i;
    logic [7:0]  pin_o;
    logic [7:0]  pin_oe;
    logic [7:0]  mir = 8'h00;
    logic [7:0]  ext_v = 8'hA5;
    logic [7:0]  ext_en = 8'hFF;
    int          n_errors = 0;
    int          n_tests = 0;

    always #2.5 mclk_i = ~mclk_i;

    gpl_bank gpl_bank_inst (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(dat_o), .wb_ack_o(ack), .wb_err_o(err), .pin_i(pin_i), .pin_o(pin_o),
        .pin_oe_o(pin_oe), .ext_mii_mode_i(mii), .mii_mirror_i(mir), .irq_o(irq),
        .wake_o(wake));
    gpl_board gpl_board_inst (.drv_i(pin_o), .drv_oe_i(pin_oe), .ext_v_i(ext_v),
        .ext_en_i(ext_en), .lvl_o(pin_i));

    task wrap_up;
        if (n_errors == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // one classic cycle; ack or err is taken at the edge where it is seen
    task wb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge mclk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'hF;
        wdat <= d;
        for (i = 0; i < 20; i++) begin
            @(posedge mclk_i);
            if (ack === 1'b1 || err === 1'b1) break;
        end
        if (i == 20) begin
            n_errors++;
            $display("BAD %0t bus cycle never answered", $time);
            wrap_up();
        end
        rdat = dat_o;
        e = err;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task wait_n(input int n);
        repeat (n) @(posedge mclk_i);
    endtask

    initial begin
        wait_n(6);
        rst_n_i <= 1'b1;
        wait_n(6);
        chk(pin_oe, 8'h00);
        wb(0, GPL_CFG_OFF, 0);
        chk(rdat, 32'hFF0000A5);
        wb(1, GPL_IMASK_OFF, 32'h0000FFFF);
        wb(1, GPL_WAKE_OFF, 32'h00000001);
        wb(1, GPL_CFG_OFF, 32'h0000003C);
        ext_v <= 8'hA6;
        wait_n(8);
        wb(0, GPL_CFG_OFF, 0);
        chk(rdat, 32'h000000A6);
        wb(0, GPL_ISTAT_OFF, 0);
        chk(rdat, 32'h00000103);
        chk({irq, wake}, 2'b11);
        wb(1, GPL_ISTAT_OFF, 32'h0000FFFF);
        wait_n(2);
        chk({irq, wake}, 2'b00);
        wb(1, GPL_CFG_OFF, 32'h00FFFF5A);
        ext_en <= 8'h00;
        wait_n(8);
        chk({pin_oe, pin_o}, 16'hFF5A);
        // toggling an output pin must not raise an event
        wb(1, GPL_CFG_OFF, 32'h00FFFFA5);
        wait_n(8);
        wb(0, GPL_ISTAT_OFF, 0);
        chk(rdat, 32'h0);
        wb(1, GPL_CFG_OFF, 32'h0000FF0F);
        wait_n(8);
        chk({pin_oe, pin_o}, 16'hF000);
        wb(0, GPL_CFG_OFF, 0);
        chk(rdat, 32'h0000FF0F);
        mir <= 8'h96;
        wb(1, GPL_CTRL_OFF, 32'h00000001);
        wb(1, GPL_CFG_OFF, 32'hFF000000);
        wait_n(2);
        chk({pin_oe, pin_o}, 16'hFF96);
        wb(1, GPL_CFG_OFF, 32'h00FFFF00);
        mii <= 1'b1;
        wait_n(8);
        chk(pin_oe, 8'h00);
        // inputs change while mii mode holds: no event may be recorded
        wb(1, GPL_CFG_OFF, 32'h00000000);
        wb(1, GPL_IMASK_OFF, 32'h0);
        ext_en <= 8'hFF;
        wait_n(8);
        wb(0, GPL_ISTAT_OFF, 0);
        chk(rdat, 32'h0);
        mii <= 1'b0;
        wait_n(8);
        ext_v <= 8'hFF;
        wait_n(8);
        wb(0, GPL_ISTAT_OFF, 0);
        chk(rdat, 32'h00000159);
        chk({irq, wake}, 2'b00);
        wb(1, GPL_IMASK_OFF, 32'h0000FFFF);
        wait_n(2);
        chk({irq, wake}, 2'b11);
        wb(0, 12'h0FC, 0);
        chk(e, 1'b1);
        wrap_up();
    end
endmodule
